// ===== common/sdr_params.svh
/*
 * Constants shared by both ends of the SDRAM link: command pin codes, mode register field positions,
 * register offsets of the controller and timing counts.
 * Assumes a 250 MHz clock (4 ns period) on both ends.
 */
`ifndef SDR_PARAMS_SVH
`define SDR_PARAMS_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define SDR_CLK_PS 4000
`define SDR_PWR_WAIT_US 100
`define SDR_PWR_WAIT_CYC ((`SDR_PWR_WAIT_US * 1000000 + `SDR_CLK_PS - 1) / `SDR_CLK_PS)
`define SDR_MRD_NS 15
`define SDR_MRD_CYC ((`SDR_MRD_NS * 1000 + `SDR_CLK_PS - 1) / `SDR_CLK_PS)
`define SDR_RP_NS 20
`define SDR_RP_CYC ((`SDR_RP_NS * 1000 + `SDR_CLK_PS - 1) / `SDR_CLK_PS)
`define SDR_RFC_NS 70
`define SDR_RFC_CYC ((`SDR_RFC_NS * 1000 + `SDR_CLK_PS - 1) / `SDR_CLK_PS)
`define SDR_RCD_NS 20
`define SDR_RCD_CYC ((`SDR_RCD_NS * 1000 + `SDR_CLK_PS - 1) / `SDR_CLK_PS)
`define SDR_REF_COUNT 2'h2

// ----------------------------------------
// command codes {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------
`define SDR_CMD_INH 4'hf
`define SDR_CMD_NOP 4'h7
`define SDR_CMD_ACT 4'h3
`define SDR_CMD_RD 4'h5
`define SDR_CMD_WR 4'h4
`define SDR_CMD_PRE 4'h2
`define SDR_CMD_REF 4'h1
`define SDR_CMD_MRS 4'h0

// ----------------------------------------
// mode register fields
// ----------------------------------------
`define SDR_LEN_LSB 0
`define SDR_BO_BIT 3
`define SDR_RL_LSB 4
`define SDR_OPM_LSB 7
`define SDR_WBM_BIT 9
`define SDR_PAR_REF_LSB 0
`define SDR_TEMP_COMP_LSB 3
`define SDR_DRV_LSB 5
`define SDR_RL_THREE 3'h3
`define SDR_PAR_REF_TWO 3'h1
`define SDR_PAR_REF_ONE 3'h2
`define SDR_PAR_REF_HALF 3'h5
`define SDR_PAR_REF_QUART 3'h6
`define SDR_AP_BIT 10

// ----------------------------------------
// controller register offsets (byte addresses)
// ----------------------------------------
`define SDR_REG_CTRL 5'h00
`define SDR_REG_STATUS 5'h04
`define SDR_REG_BASE_MODE 5'h08
`define SDR_REG_EXT_MODE 5'h0c
`define SDR_REG_ACCESS 5'h10
`define SDR_REG_WDATA 5'h14
`define SDR_REG_RDATA 5'h18
`define SDR_BASE_RESET 14'h0022
`define SDR_EXT_RESET 14'h0000

`endif

// ===== common/sdr_pkg.sv
/*
 * Types of the SDRAM link: decoded commands, controller states and the state records of both ends.
 * Assumes sdr_params.svh is on the include path.
 */
`include "sdr_params.svh"

package sdr_pkg;

  typedef enum {CMD_INH, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS, CMD_BST} sdr_cmd_t;

  typedef enum {ST_IDLE, ST_PWR, ST_PRE, ST_REF, ST_MRS, ST_EMRS, ST_READY, ST_ACT, ST_RW, ST_RDCAP,
                ST_CLOSE, ST_WAIT} sdr_ctl_st_t;

  typedef struct packed {
    logic [11:0] base_mode;
    logic [11:0] ext_mode;
    logic base_loaded;
    logic ext_loaded;
    logic [3:0] refresh_mask;
    logic [1:0] rd_wait;
    logic rd_act;
    logic wr_act;
    logic [2:0] beat;
    logic [1:0] bank;
    logic [7:0] col_start;
    logic [15:0] dq;
    logic dq_oe;
  } sdr_dev_t;

  typedef struct packed {
    sdr_ctl_st_t st;
    sdr_ctl_st_t ret;
    logic [15:0] cnt;
    logic [1:0] refs;
    logic [3:0] cmd;
    logic [1:0] ba;
    logic [11:0] addr;
    logic [15:0] dq;
    logic dq_oe;
    logic dqm;
    logic ack;
    logic [31:0] dat;
    logic [13:0] base_mode;
    logic [13:0] ext_mode;
    logic [23:0] access;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic rd_valid;
    logic init_done;
    logic is_write;
  } sdr_ctl_t;

  function automatic sdr_cmd_t sdr_decode(input logic [3:0] pins);
    case (pins)
      `SDR_CMD_NOP: sdr_decode = CMD_NOP;
      `SDR_CMD_ACT: sdr_decode = CMD_ACT;
      `SDR_CMD_RD: sdr_decode = CMD_RD;
      `SDR_CMD_WR: sdr_decode = CMD_WR;
      `SDR_CMD_PRE: sdr_decode = CMD_PRE;
      `SDR_CMD_REF: sdr_decode = CMD_REF;
      `SDR_CMD_MRS: sdr_decode = CMD_MRS;
      4'h6: sdr_decode = CMD_BST;
      default: sdr_decode = CMD_INH;
    endcase
  endfunction : sdr_decode

  // first word is valid at edge n + latency; codes other than three run at two
  function automatic logic [1:0] sdr_latency(input logic [2:0] field);
    sdr_latency = (field == `SDR_RL_THREE) ? 2'h3 : 2'h2;
  endfunction : sdr_latency

endpackage : sdr_pkg

// ===== common/sdr_link_if.sv
/*
 * Link between controller and memory device: command pins, bank and address, data mask and both
 * directions of the data bus split into value and enable.
 * Assumes both ends run on the same clock; each end reads the other end's data value directly, with no shared wire.
 */
`timescale 1ns/10ps

interface sdr_link_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] ba;
  logic [11:0] addr;
  logic dqm;
  logic [15:0] ctl_dq;
  logic ctl_dq_oe;
  logic [15:0] mem_dq;
  logic mem_dq_oe;

  modport ctrl (output cs_n, ras_n, cas_n, we_n, ba, addr, dqm, ctl_dq, ctl_dq_oe, input mem_dq, mem_dq_oe);
  modport mem (input cs_n, ras_n, cas_n, we_n, ba, addr, dqm, ctl_dq, ctl_dq_oe, output mem_dq, mem_dq_oe);
endinterface : sdr_link_if

// ===== design/sdr_mem_dev.sv
/*
 * Memory end of the link: decodes commands, holds base and extended mode registers, runs read and
 * write bursts in sequential or interleaved order with programmed read latency.
 * Assumes the controller keeps the power-up sequence and mode-load spacing. Rows are not modelled:
 * storage is one 16-bit word per column, 256 columns in each bank.
 */
`timescale 1ns/10ps
`include "sdr_params.svh"

module sdr_mem_dev
  import sdr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  sdr_link_if.mem link,
  output logic [11:0] base_mode_o,
  output logic [11:0] ext_mode_o,
  output logic base_loaded_o,
  output logic ext_loaded_o,
  output logic [3:0] refresh_mask_o,
  output logic [1:0] drive_sel_o
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // low column bits of beat k within the aligned block of the burst
  function automatic logic [7:0] burst_col(input logic [7:0] start, input logic [2:0] k,
                                           input logic [2:0] len_code, input logic interleave);
    logic [2:0] mask;
    logic [2:0] off;
    mask = 3'h0;
    case (len_code)
      3'h1: mask = 3'h1;
      3'h2: mask = 3'h3;
      3'h3: mask = 3'h7;
      default: mask = 3'h0;
    endcase
    off = interleave ? (start[2:0] ^ k) : 3'((start[2:0] + k));
    burst_col = {start[7:3], (start[2:0] & ~mask) | (off & mask)};
  endfunction : burst_col

  function automatic logic [2:0] burst_last(input logic [2:0] len_code);
    case (len_code)
      3'h1: burst_last = 3'h1;
      3'h2: burst_last = 3'h3;
      3'h3: burst_last = 3'h7;
      default: burst_last = 3'h0;
    endcase
  endfunction : burst_last

  // ----------------------------------------
  // state
  // ----------------------------------------
  sdr_dev_t s;
  sdr_dev_t next_s;
  logic [15:0] mem [0:1023];
  logic wr_en;
  logic [9:0] wr_idx;
  sdr_cmd_t cmd;
  logic [2:0] len_code;
  logic [2:0] last;
  logic [7:0] col_now;

  always_comb begin
    cmd = sdr_decode({link.cs_n, link.ras_n, link.cas_n, link.we_n});
    len_code = s.base_mode[`SDR_LEN_LSB +: 3];
    last = burst_last(len_code);
    next_s = s;
    wr_en = 1'b0;
    wr_idx = 10'h000;
    col_now = burst_col(s.col_start, s.beat, len_code, s.base_mode[`SDR_BO_BIT]);
    // ----------------------------------------
    // burst in progress
    // ----------------------------------------
    if (s.rd_act) begin
      if (s.beat == last) begin
        next_s.rd_act = 1'b0;
        next_s.dq_oe = 1'b0;
      end else begin
        next_s.beat = s.beat + 3'h1;
        next_s.dq = mem[{s.bank, burst_col(s.col_start, s.beat + 3'h1, len_code, s.base_mode[`SDR_BO_BIT])}];
      end
    end else if (s.rd_wait != 2'h0) begin
      next_s.rd_wait = s.rd_wait - 2'h1;
      if (s.rd_wait == 2'h1) begin
        // bus turns on one edge before the first word must be valid
        next_s.rd_act = 1'b1;
        next_s.dq_oe = 1'b1;
        next_s.beat = 3'h0;
        next_s.dq = mem[{s.bank, burst_col(s.col_start, 3'h0, len_code, s.base_mode[`SDR_BO_BIT])}];
      end
    end
    if (s.wr_act) begin
      wr_en = ~link.dqm;
      wr_idx = {s.bank, col_now};
      if (s.beat == last) begin
        next_s.wr_act = 1'b0;
      end else begin
        next_s.beat = s.beat + 3'h1;
      end
    end
    // ----------------------------------------
    // new command
    // ----------------------------------------
    case (cmd)
      CMD_MRS: begin
        if (link.ba == 2'h2) begin
          next_s.ext_mode = link.addr;
          next_s.ext_loaded = 1'b1;
          // temperature bits are stored but steer nothing
          case (link.addr[`SDR_PAR_REF_LSB +: 3])
            `SDR_PAR_REF_TWO: next_s.refresh_mask = 4'h3;
            `SDR_PAR_REF_ONE, `SDR_PAR_REF_HALF, `SDR_PAR_REF_QUART: next_s.refresh_mask = 4'h1;
            default: next_s.refresh_mask = 4'hf;
          endcase
        end else if (link.ba == 2'h0) begin
          next_s.base_mode = link.addr;
          next_s.base_loaded = 1'b1;
        end
      end
      CMD_RD: begin
        if (s.base_loaded) begin
          next_s.rd_wait = sdr_latency(s.base_mode[`SDR_RL_LSB +: 3]) - 2'h1;
          next_s.rd_act = 1'b0;
          next_s.wr_act = 1'b0;
          next_s.dq_oe = 1'b0;
          next_s.bank = link.ba;
          next_s.col_start = link.addr[7:0];
        end
      end
      CMD_WR: begin
        if (s.base_loaded) begin
          wr_en = ~link.dqm;
          wr_idx = {link.ba, link.addr[7:0]};
          next_s.rd_act = 1'b0;
          next_s.rd_wait = 2'h0;
          next_s.dq_oe = 1'b0;
          next_s.bank = link.ba;
          next_s.col_start = link.addr[7:0];
          next_s.beat = 3'h1;
          // single-location writes when write burst mode is set
          next_s.wr_act = (last != 3'h0) && !s.base_mode[`SDR_WBM_BIT];
        end
      end
      CMD_BST: begin
        next_s.rd_act = 1'b0;
        next_s.rd_wait = 2'h0;
        next_s.wr_act = 1'b0;
        next_s.dq_oe = 1'b0;
      end
      default: begin
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // mode words change only on a load; reset is the bench's power-up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.refresh_mask <= 4'hf;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i && !rst_i && wr_en) begin
      mem[wr_idx] <= link.ctl_dq;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign link.mem_dq = s.dq;
  assign link.mem_dq_oe = s.dq_oe;
  assign base_mode_o = s.base_mode;
  assign ext_mode_o = s.ext_mode;
  assign base_loaded_o = s.base_loaded;
  assign ext_loaded_o = s.ext_loaded;
  assign refresh_mask_o = s.refresh_mask;
  assign drive_sel_o = s.ext_mode[`SDR_DRV_LSB +: 2];

endmodule : sdr_mem_dev

// ===== design/sdr_mem_ctl.sv
/*
 * Controller end of the link: power-up sequence, mode and extended mode loads, and single-word
 * reads and writes ordered over a classic Wishbone slave.
 * Assumes the memory end shares clk_i; software keeps mode words legal.
 */
`timescale 1ns/10ps
`include "sdr_params.svh"

module sdr_mem_ctl
  import sdr_pkg::*;
#(
  parameter int PWR_WAIT_CYC = `SDR_PWR_WAIT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  sdr_link_if.ctrl link,
  input wire logic [4:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  sdr_ctl_t s;
  sdr_ctl_t next_s;
  logic wb_hit;

  always_comb begin
    next_s = s;
    wb_hit = wb_cyc_i && wb_stb_i && !s.ack;
    next_s.ack = wb_hit;
    next_s.cmd = `SDR_CMD_NOP;
    next_s.dq_oe = 1'b0;
    // ----------------------------------------
    // register bus
    // ----------------------------------------
    if (wb_hit) begin
      next_s.dat = 32'h0000_0000;
      if (wb_we_i && wb_sel_i[0]) begin
        case (wb_adr_i)
          `SDR_REG_CTRL: begin
            if (wb_dat_i[0] && s.st == ST_IDLE) begin
              next_s.st = ST_PWR;
              next_s.cnt = 16'(PWR_WAIT_CYC);
            end
            if (wb_dat_i[1] && s.st == ST_READY) begin
              next_s.st = ST_ACT;
              next_s.is_write = wb_dat_i[2];
              next_s.rd_valid = 1'b0;
            end
          end
          `SDR_REG_BASE_MODE: next_s.base_mode = wb_dat_i[13:0];
          `SDR_REG_EXT_MODE: next_s.ext_mode = wb_dat_i[13:0];
          `SDR_REG_ACCESS: next_s.access = wb_dat_i[23:0];
          `SDR_REG_WDATA: next_s.wdata = wb_dat_i[15:0];
          default: begin
          end
        endcase
      end else if (!wb_we_i) begin
        case (wb_adr_i)
          `SDR_REG_STATUS: next_s.dat = {29'h0, s.rd_valid, s.st != ST_READY && s.st != ST_IDLE, s.init_done};
          `SDR_REG_BASE_MODE: next_s.dat = {18'h0, s.base_mode};
          `SDR_REG_EXT_MODE: next_s.dat = {18'h0, s.ext_mode};
          `SDR_REG_ACCESS: next_s.dat = {8'h0, s.access};
          `SDR_REG_WDATA: next_s.dat = {16'h0, s.wdata};
          `SDR_REG_RDATA: next_s.dat = {16'h0, s.rdata};
          default: next_s.dat = 32'h0000_0000;
        endcase
      end
    end
    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    case (s.st)
      ST_PWR: begin
        if (s.cnt <= 16'h0001) begin
          next_s.st = ST_PRE;
        end else begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end
      ST_PRE: begin
        next_s.cmd = `SDR_CMD_PRE;
        next_s.addr = 12'h000;
        next_s.addr[`SDR_AP_BIT] = 1'b1;
        next_s.cnt = 16'(`SDR_RP_CYC);
        next_s.ret = s.init_done ? ST_READY : ST_REF;
        next_s.refs = 2'h0;
        next_s.st = ST_WAIT;
      end
      ST_REF: begin
        next_s.cmd = `SDR_CMD_REF;
        next_s.refs = s.refs + 2'h1;
        next_s.cnt = 16'(`SDR_RFC_CYC);
        next_s.ret = (s.refs + 2'h1 == `SDR_REF_COUNT) ? ST_MRS : ST_REF;
        next_s.st = ST_WAIT;
      end
      ST_MRS: begin
        next_s.cmd = `SDR_CMD_MRS;
        next_s.ba = 2'h0;
        next_s.addr = {2'h0, s.base_mode[9:0]};
        next_s.addr[`SDR_OPM_LSB +: 2] = 2'h0;
        next_s.cnt = 16'(`SDR_MRD_CYC);
        next_s.ret = ST_EMRS;
        next_s.st = ST_WAIT;
      end
      ST_EMRS: begin
        next_s.cmd = `SDR_CMD_MRS;
        next_s.ba = 2'h2;
        next_s.addr = s.ext_mode[11:0];
        next_s.cnt = 16'(`SDR_MRD_CYC);
        next_s.ret = ST_READY;
        next_s.init_done = 1'b1;
        next_s.st = ST_WAIT;
      end
      ST_ACT: begin
        next_s.cmd = `SDR_CMD_ACT;
        next_s.ba = s.access[9:8];
        next_s.addr = s.access[21:10];
        next_s.cnt = 16'(`SDR_RCD_CYC);
        next_s.ret = ST_RW;
        next_s.st = ST_WAIT;
      end
      ST_RW: begin
        next_s.cmd = s.is_write ? `SDR_CMD_WR : `SDR_CMD_RD;
        next_s.ba = s.access[9:8];
        next_s.addr = {4'h0, s.access[7:0]};
        next_s.dq = s.wdata;
        next_s.dq_oe = s.is_write;
        next_s.dqm = 1'b0;
        // memory registers the read one edge after we launch it, so wait latency edges
        next_s.cnt = {14'h0, sdr_latency(s.base_mode[`SDR_RL_LSB +: 3])};
        next_s.st = s.is_write ? ST_CLOSE : ST_RDCAP;
      end
      ST_RDCAP: begin
        if (s.cnt == 16'h0000) begin
          next_s.rdata = link.mem_dq;
          next_s.rd_valid = 1'b1;
          next_s.st = ST_CLOSE;
        end else begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end
      ST_CLOSE: begin
        // mask the rest of a write burst, only one word was supplied
        next_s.dqm = 1'b1;
        next_s.st = ST_PRE;
      end
      ST_WAIT: begin
        if (s.cnt <= 16'h0001) begin
          next_s.st = s.ret;
        end else begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.cmd <= `SDR_CMD_INH;
      s.dqm <= 1'b1;
      s.base_mode <= `SDR_BASE_RESET;
      s.ext_mode <= `SDR_EXT_RESET;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = s.cmd;
  assign link.ba = s.ba;
  assign link.addr = s.addr;
  assign link.dqm = s.dqm;
  assign link.ctl_dq = s.dq;
  assign link.ctl_dq_oe = s.dq_oe;
  assign wb_dat_o = s.dat;
  assign wb_ack_o = s.ack;

endmodule : sdr_mem_ctl

// ===== verif/sdr_link_sva.sv
/*
 * Checker of the controller-to-memory link: init order, mode loads, write data and read timing.
 * Assumes one clock, a synchronous active-high reset and sdr_params.svh on the include path.
 */
`timescale 1ns/10ps
`include "sdr_params.svh"

module sdr_link_sva #(
  parameter int PWR_WAIT_CYC = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [11:0] addr,
  input wire logic dqm,
  input wire logic ctl_dq_oe,
  input wire logic mem_dq_oe
);
  logic [3:0] cmd;
  logic [15:0] nops;
  logic pre_seen;
  logic [1:0] refs;
  logic base_seen;
  logic lat3;
  logic [3:0] blen;
  logic [3:0] run;
  assign cmd = {cs_n, ras_n, cas_n, we_n};

  // --------------------------------
  // link history
  // --------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nops <= 16'h0;
      pre_seen <= 1'b0;
      refs <= 2'h0;
      base_seen <= 1'b0;
      lat3 <= 1'b0;
      blen <= 4'h1;
      run <= 4'h0;
    end else begin
      run <= mem_dq_oe ? run + 4'h1 : 4'h0;
      if (!pre_seen && (cmd == `SDR_CMD_NOP || cmd == `SDR_CMD_INH) && nops != 16'hffff) begin
        nops <= nops + 16'h1;
      end
      if (cmd == `SDR_CMD_PRE) begin
        pre_seen <= 1'b1;
      end
      if (cmd == `SDR_CMD_REF && refs != 2'h2) begin
        refs <= refs + 2'h1;
      end
      if (cmd == `SDR_CMD_MRS && ba == 2'h0) begin
        base_seen <= 1'b1;
        lat3 <= addr[6:4] == 3'h3;
        blen <= addr[2] ? 4'h1 : 4'h1 << addr[1:0];
      end
    end
  end

  // --------------------------------
  // properties
  // --------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_mrs;
    cmd == `SDR_CMD_MRS;
  endsequence
  sequence s_rd;
    cmd == `SDR_CMD_RD && !mem_dq_oe;
  endsequence

  a_pwr_wait_kept: assert property (!pre_seen && cmd != `SDR_CMD_NOP && cmd != `SDR_CMD_INH |->
    nops >= PWR_WAIT_CYC) else $error("command before power-up wait");
  a_pre_all_banks: assert property (cmd == `SDR_CMD_PRE && !pre_seen |-> addr[10])
    else $error("first precharge not all banks");
  a_ref_after_pre: assert property (cmd == `SDR_CMD_REF |-> pre_seen) else $error("refresh before precharge");
  a_mrs_after_refs: assert property (s_mrs |-> refs == 2'h2) else $error("mode load before two refreshes");
  a_mrs_gap: assert property (s_mrs |=> (cmd == `SDR_CMD_NOP)[*3]) else $error("mode load wait broken");
  a_mrs_bank_sel: assert property (s_mrs |-> ba == 2'h0 || ba == 2'h2) else $error("mode load bad bank");
  a_op_mode_zero: assert property (s_mrs and ba == 2'h0 |-> addr[8:7] == 2'h0) else $error("op mode set");
  a_access_after_base: assert property (cmd inside {`SDR_CMD_ACT, `SDR_CMD_RD, `SDR_CMD_WR} |-> base_seen)
    else $error("access before base mode load");
  a_wr_data_with_cmd: assert property (cmd == `SDR_CMD_WR |-> ctl_dq_oe && !dqm)
    else $error("write without data");
  a_rd_lat_two: assert property (s_rd and !lat3 |=> !mem_dq_oe ##1 mem_dq_oe)
    else $error("latency two timing");
  a_rd_lat_three: assert property (s_rd and lat3 |=> !mem_dq_oe ##1 !mem_dq_oe ##1 mem_dq_oe)
    else $error("latency three timing");
  a_burst_len: assert property ($fell(mem_dq_oe) |-> run == blen) else $error("burst length wrong");

endmodule : sdr_link_sva

// ===== verif/sdram_init_and_mode_config_tb.sv
/*
 * Bench of both link ends: Wishbone orders init, mode loads and accesses; beats seen on the link.
 * Assumes sdr_params.svh on the include path and the controller's register map.
 */
`timescale 1ns/10ps
`include "sdr_params.svh"

module sdram_init_and_mode_config_tb;
  localparam int PWR = 20;
  logic clk_i;
  logic rst_i;
  logic [4:0] wb_adr;
  logic [31:0] wb_dw;
  logic [3:0] wb_sel;
  logic wb_we, wb_cyc, wb_stb, wb_ack;
  logic [31:0] wb_dr;
  logic [11:0] base_mode, ext_mode;
  logic base_ld, ext_ld;
  logic [3:0] mask;
  logic [1:0] drv;
  logic [15:0] beats[$];
  int err_total = 0;
  int compares = 0;

  sdr_link_if link ();
  sdr_mem_ctl #(.PWR_WAIT_CYC(PWR)) u_sdr_mem_ctl (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .link(link.ctrl),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_dw), .wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_dat_o(wb_dr), .wb_ack_o(wb_ack));
  sdr_mem_dev u_sdr_mem_dev (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .link(link.mem),
    .base_mode_o(base_mode), .ext_mode_o(ext_mode), .base_loaded_o(base_ld), .ext_loaded_o(ext_ld),
    .refresh_mask_o(mask), .drive_sel_o(drv));
  sdr_link_sva #(.PWR_WAIT_CYC(PWR)) u_sdr_link_sva (.clk_i(clk_i), .rst_i(rst_i), .cs_n(link.cs_n),
    .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba), .addr(link.addr),
    .dqm(link.dqm), .ctl_dq_oe(link.ctl_dq_oe), .mem_dq_oe(link.mem_dq_oe));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (link.mem_dq_oe === 1'b1) begin
      beats.push_back(link.mem_dq);
    end
  end

  // --------------------------------
  // tasks
  // --------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic [4:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_adr <= a;
    wb_we <= w;
    wb_dw <= d;
    wb_sel <= 4'hf;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    q = wb_dr;
    chk(32'(wb_ack), 32'h1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb

  task automatic poll(input int b, input logic v);
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      wb(`SDR_REG_STATUS, 1'b0, 32'h0, s);
      n++;
    end while (s[b] !== v && n < 200);
    chk(32'(s[b]), 32'(v));
  endtask : poll

  task automatic access(input logic [7:0] c, input logic wr);
    logic [31:0] q;
    wb(`SDR_REG_ACCESS, 1'b1, {22'h0, 2'h2, c}, q);
    wb(`SDR_REG_WDATA, 1'b1, {16'h0, 8'h5a, c}, q);
    wb(`SDR_REG_CTRL, 1'b1, {29'h0, wr, 2'h2}, q);
    poll(1, 1'b0);
  endtask : access

  function automatic logic [7:0] col_of(input logic [7:0] st, input int k, input int len, input logic il);
    logic [7:0] m;
    m = 8'(len - 1);
    col_of = il ? (st ^ 8'(k)) : ((st & ~m) | ((st + 8'(k)) & m));
  endfunction : col_of

  // one scenario per mode pair: init, block fill, one burst read from st
  task automatic t_cfg(input logic [13:0] bm, input logic [13:0] em, input logic [3:0] exp_mask,
    input logic [7:0] st);
    logic [31:0] q;
    int blen;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(32'(base_ld), 32'h0);
    wb(`SDR_REG_BASE_MODE, 1'b1, {18'h0, bm}, q);
    wb(`SDR_REG_EXT_MODE, 1'b1, {18'h0, em}, q);
    wb(`SDR_REG_CTRL, 1'b1, 32'h1, q);
    poll(0, 1'b1);
    // access start is ignored until the last mode-load wait is over
    poll(1, 1'b0);
    chk(32'(base_ld), 32'h1);
    chk(32'(ext_ld), 32'h1);
    chk(32'(base_mode), 32'(bm[11:0]));
    chk(32'(ext_mode), 32'(em[11:0]));
    chk(32'(mask), 32'(exp_mask));
    chk(32'(drv), 32'(em[6:5]));
    wb(`SDR_REG_BASE_MODE, 1'b0, 32'h0, q);
    chk(q, {18'h0, bm});
    wb(5'h1c, 1'b0, 32'h0, q);
    chk(q, 32'h0);
    blen = 1 << bm[1:0];
    for (int k = 0; k < blen; k++) begin
      access(col_of(st, k, blen, 1'b0), 1'b1);
    end
    beats.delete();
    access(st, 1'b0);
    poll(2, 1'b1);
    wb(`SDR_REG_RDATA, 1'b0, 32'h0, q);
    chk(q, {16'h0, 8'h5a, st});
    // longest burst ends ten edges after the read is taken
    repeat (12) @(posedge clk_i);
    chk(32'(beats.size()), 32'(blen));
    for (int k = 0; k < blen && k < beats.size(); k++) begin
      chk(32'(beats[k]), {16'h0, 8'h5a, col_of(st, k, blen, bm[3])});
    end
    $display("test done base %h ext %h", bm, em);
  endtask : t_cfg

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    rst_i = 1'b1;
    wb_adr = 5'h0;
    wb_dw = 32'h0;
    wb_sel = 4'hf;
    wb_we = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    repeat (2) @(posedge clk_i);
    t_cfg(14'h003a, 14'h0021, 4'h3, 8'h45);
    t_cfg(14'h0023, 14'h005d, 4'h1, 8'h13);
    t_cfg(14'h0029, 14'h0006, 4'h1, 8'h31);
    t_cfg(14'h0230, 14'h0062, 4'h1, 8'h20);
    t_cfg(14'h0032, 14'h0000, 4'hf, 8'h02);
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    $display("ERROR %0t watchdog expired", $time);
    final_report();
  end

endmodule : sdram_init_and_mode_config_tb
